// File: design/serial_port_pkg.sv
/*
 * Shared constants and types for the serial port clock, frame and
 * transmitter control block: register indices, field layouts, reset
 * values and the divider figures.
 * Assumes a 32-bit APB master that addresses each register as one
 * aligned word at four times its index.
 */
package serial_port_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [29:0] CTRL_A_INDEX = 30'h0FFFFB5;
    localparam logic [29:0] CTRL_B_INDEX = 30'h0FFFFB6;
    localparam int          REG_WIDTH    = 24;
    localparam logic [23:0] CTRL_A_RESET = 24'h000000;
    localparam logic [23:0] CTRL_B_RESET = 24'h000000;
    // Reserved bits 10..8 of control A are not stored and read as zero.
    localparam logic [23:0] CTRL_A_MASK  = 24'hFFF8FF;

    // ------------------------------------------------------------
    // Clock generator figures
    // ------------------------------------------------------------
    localparam logic [2:0]  FIXED_STAGE_LIMIT = 3'h7;
    localparam int          BCLK_MIN_DIV      = 4;
    localparam int          BCLK_MAX_DIV      = 4096;

    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic [6:0] upper_fields;
        logic [4:0] frame_divider;
        logic       prescaler_range_bit;
        logic [2:0] reserved;
        logic [7:0] prescale_modulus;
    } ctrl_a_t;

    typedef struct packed {
        logic       rx_exception_irq_on;
        logic       tx_exception_irq_on;
        logic       rx_last_slot_irq_on;
        logic       tx_last_slot_irq_on;
        logic       rx_irq_on;
        logic       tx_irq_on;
        logic       rx_on_bit;
        logic       first_transmitter_on;
        logic       second_transmitter_on;
        logic       third_transmitter_on;
        logic       network_select;
        logic       shared_clock_mode;
        logic [5:0] spare;
        logic [2:0] pin_dir;
        logic       clock_dir;
        logic       flag_out_b;
        logic       flag_out_a;
    } ctrl_b_t;

    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe;
    } sc_pins_t;

    typedef enum logic {
        WORD_IDLE = 1'b0,
        WORD_RUN  = 1'b1
    } word_state_t;

endpackage : serial_port_pkg

// File: design/ratio_counter.sv
/*
 * Programmable modulus counter: steps on an enable and wraps after
 * limit+1 steps, giving a one-cycle registered wrap pulse.
 * Assumes one clock and a synchronous active-high reset.
 */
module ratio_counter #(
    parameter int W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    input  wire logic         step,
    input  wire logic [W-1:0] limit,
    output logic      [W-1:0] count,
    output logic              wrap
);

    // A limit lowered below the current count wraps on the next step, so a
    // reprogrammed ratio never leaves the counter running to 2**W.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count <= '0;
            wrap  <= 1'b0;
        end else begin
            wrap <= 1'b0;
            if (step) begin
                if (count >= limit) begin
                    count <= '0;
                    wrap  <= 1'b1;
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end

endmodule : ratio_counter

// File: design/serial_port_clock_frame_control.sv
/*
 * Bit clock prescaler, frame rate divider, transmitter enables and
 * output flag control of a synchronous serial port, with two control
 * registers reached over APB.
 * Assumes the shift registers and data registers live outside: they
 * report data ready for the first transmitter and supply serial bits.
 */
// The APB interface to the registers was decided locally.
module serial_port_clock_frame_control
    import serial_port_pkg::*;
#(
    parameter int WORD_BITS = 24
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        soft_reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx0_data_valid,
    input  wire logic [2:0]  tx_serial,
    output logic             bit_clock_pin,
    output logic             bit_clock_oe,
    output logic             serial_data_out_pin,
    output logic             serial_data_out_oe,
    output sc_pins_t         multifunction_pins,
    output logic             shift_strobe,
    output logic             frame_sync,
    output logic             tx0_load,
    output logic [2:0]       tx_active,
    output logic             rx_active
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_A_ADDR = {CTRL_A_INDEX, 2'b00};
    localparam logic [31:0] CTRL_B_ADDR = {CTRL_B_INDEX, 2'b00};
    localparam int          BIT_W       = $clog2(WORD_BITS);
    localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(WORD_BITS - 1);

    ctrl_a_t           serial_control_a;
    ctrl_b_t           serial_control_b;
    logic              bus_access;
    logic              hit_a;
    logic              hit_b;
    logic [2:0]        fixed_count;
    logic              fixed_wrap;
    logic              modulus_step;
    logic [7:0]        modulus_count;
    logic              modulus_wrap;
    logic              bclk;
    logic              bit_tick;
    word_state_t       word_state;
    logic [BIT_W-1:0]  bit_cnt;
    logic              word_start;
    logic              word_end;
    logic [4:0]        word_idx;
    logic              on_demand;
    logic              frame_first;
    logic [2:0]        te_req;
    logic [2:0]        te_dropped;
    logic [2:0]        te_eff;
    logic [1:0]        flag_pins;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // The answer comes one cycle into the access phase, so every
    // output of the slave stays a plain flip-flop.
    assign bus_access = psel && penable && pready;
    assign hit_a      = (paddr == CTRL_A_ADDR);
    assign hit_b      = (paddr == CTRL_B_ADDR);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= !(hit_a || hit_b);
            if (!pwrite && hit_a) begin
                prdata <= {8'h00, serial_control_a};
            end else if (!pwrite && hit_b) begin
                prdata <= {8'h00, serial_control_b};
            end else begin
                prdata <= 32'h00000000;
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            serial_control_a <= CTRL_A_RESET;
        end else if (bus_access && pwrite && hit_a) begin
            serial_control_a <= pwdata[REG_WIDTH-1:0] & CTRL_A_MASK;
        end
    end

    // Software reset wins over a write landing in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || soft_reset) begin
            serial_control_b <= CTRL_B_RESET;
        end else if (bus_access && pwrite && hit_b) begin
            serial_control_b <= pwdata[REG_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------
    // Bit clock generator
    // ------------------------------------------------------------
    // Fixed divide-by-eight stage, then the variable prescaler, then
    // a toggle that halves the rate again.
    ratio_counter #(.W(3)) fixed_stage (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .step    (1'b1),
        .limit   (FIXED_STAGE_LIMIT),
        .count   (fixed_count),
        .wrap    (fixed_wrap)
    );

    assign modulus_step = serial_control_a.prescaler_range_bit ? 1'b1 : fixed_wrap;

    ratio_counter #(.W(8)) modulus_stage (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .step    (modulus_step),
        .limit   (serial_control_a.prescale_modulus),
        .count   (modulus_count),
        .wrap    (modulus_wrap)
    );

    // With the fixed stage bypassed and a zero modulus the wrap comes
    // every cycle and the bit clock runs at half the core clock; that
    // setting is left to software to avoid, so a quarter is the top.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bclk <= 1'b0;
        end else if (modulus_wrap) begin
            bclk <= !bclk;
        end
    end

    // Data moves on the falling edge of the bit clock.
    assign bit_tick = modulus_wrap && bclk;

    // ------------------------------------------------------------
    // Word sequencing
    // ------------------------------------------------------------
    assign on_demand = serial_control_b.network_select
                       && (serial_control_a.frame_divider == 5'h00);

    // In on-demand operation a word only runs while the first
    // transmitter has data; otherwise words follow back to back.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            word_state <= WORD_IDLE;
        end else begin
            case (word_state)
                WORD_IDLE: begin
                    if (!on_demand || (bit_tick && tx0_data_valid)) begin
                        word_state <= WORD_RUN;
                    end
                end
                WORD_RUN: begin
                    if (on_demand && word_end && !tx0_data_valid) begin
                        word_state <= WORD_IDLE;
                    end
                end
                default: begin
                    word_state <= WORD_IDLE;
                end
            endcase
        end
    end

    assign word_start = bit_tick && (word_state == WORD_RUN) && (bit_cnt == '0);
    assign word_end   = bit_tick && (word_state == WORD_RUN) && (bit_cnt == LAST_BIT);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bit_cnt <= '0;
        end else if (bit_tick && (word_state == WORD_RUN)) begin
            bit_cnt <= (bit_cnt == LAST_BIT) ? '0 : bit_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Frame divider
    // ------------------------------------------------------------
    // The word index wraps after frame_divider+1 words; a zero code
    // makes every word a frame, which is both the continuous normal
    // case and the on-demand network case.
    ratio_counter #(.W(5)) frame_stage (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .step    (word_end),
        .limit   (serial_control_a.frame_divider),
        .count   (word_idx),
        .wrap    ()
    );

    assign frame_first = word_start && (word_idx == 5'h00);

    // One bit long frame sync over the first bit of each frame.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            frame_sync <= 1'b0;
        end else if (frame_first) begin
            frame_sync <= 1'b1;
        end else if (bit_tick) begin
            frame_sync <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            shift_strobe <= 1'b0;
        end else begin
            shift_strobe <= bit_tick && (word_state == WORD_RUN);
        end
    end

    // ------------------------------------------------------------
    // Transmitter enables
    // ------------------------------------------------------------
    assign te_req = {serial_control_b.first_transmitter_on,
                     serial_control_b.second_transmitter_on,
                     serial_control_b.third_transmitter_on};

    // All three enables share one structure; only the first drives
    // the dedicated data pin and gates the first data register load.
    for (genvar i = 0; i < 3; i++) begin : g_tx_enable
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                te_dropped[i] <= 1'b0;
            end else if (frame_first) begin
                te_dropped[i] <= 1'b0;
            end else if (serial_control_b.network_select && te_eff[i] && !te_req[i]) begin
                te_dropped[i] <= 1'b1;
            end
        end

        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                te_eff[i] <= 1'b0;
            end else if (frame_first) begin
                te_eff[i] <= te_req[i];
            end else if (word_end && (!te_req[i] || te_dropped[i])) begin
                te_eff[i] <= 1'b0;
            end else if (!serial_control_b.network_select && word_start) begin
                te_eff[i] <= te_req[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_active <= 3'b000;
            rx_active <= 1'b0;
        end else begin
            tx_active <= te_eff;
            rx_active <= serial_control_b.rx_on_bit;
        end
    end

    // ------------------------------------------------------------
    // Output flags and first transmitter load
    // ------------------------------------------------------------
    // Flags written by software wait in control B and only reach the
    // pins together with the word that the first transmitter loads.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flag_pins <= 2'b00;
            tx0_load  <= 1'b0;
        end else begin
            tx0_load <= word_start && te_eff[2] && tx0_data_valid;
            if (word_start && te_eff[2] && tx0_data_valid) begin
                flag_pins <= {serial_control_b.flag_out_b, serial_control_b.flag_out_a};
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bit_clock_pin       <= 1'b0;
            bit_clock_oe        <= 1'b0;
            serial_data_out_pin <= 1'b0;
            serial_data_out_oe  <= 1'b0;
        end else begin
            bit_clock_pin       <= bclk;
            bit_clock_oe        <= serial_control_b.clock_dir;
            serial_data_out_pin <= tx_serial[0];
            serial_data_out_oe  <= te_eff[2];
        end
    end

    // In shared clock mode pins 0 and 1 carry the data of the second
    // and third transmitters, or the flags when those are off; in
    // separate clock mode they carry the receive clock and sync.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            multifunction_pins <= '0;
        end else begin
            multifunction_pins.oe <= serial_control_b.pin_dir;
            if (serial_control_b.shared_clock_mode) begin
                multifunction_pins.out[0] <= te_eff[1] ? tx_serial[1] : flag_pins[0];
                multifunction_pins.out[1] <= te_eff[0] ? tx_serial[2] : flag_pins[1];
            end else begin
                multifunction_pins.out[0] <= bclk;
                multifunction_pins.out[1] <= frame_sync;
            end
            multifunction_pins.out[2] <= frame_sync;
        end
    end

endmodule : serial_port_clock_frame_control

// File: test/serial_port_checker.sv
/* Concurrent checks on the APB, receive enable, bit clock enable and transmit ports of the serial port control block.
   Assumes one clock domain and a bind onto the top module. */
module serial_port_checker
    import serial_port_pkg::*;
#(
    parameter int WORD_BITS = 24
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        soft_reset,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        tx0_data_valid,
    input  wire logic        shift_strobe,
    input  wire logic        tx0_load,
    input  wire logic        rx_active,
    input  wire logic        bit_clock_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_A = {CTRL_A_INDEX, 2'h0};
    localparam logic [31:0] ADDR_B = {CTRL_B_INDEX, 2'h0};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic mapped;
    logic wr_b;
    logic exp_rx;
    assign mapped = (paddr == ADDR_A) || (paddr == ADDR_B);
    assign wr_b   = pready && pwrite && (paddr == ADDR_B) && !soft_reset;
    // The expected enable is latched so that a later write cannot blur it.
    always_ff @(posedge sys_clk) begin
        if (wr_b) begin
            exp_rx <= pwdata[17];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_err_unmapped: assert property (pready |-> (pslverr == !mapped))
        else $error("error response does not match the address map");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error response without ready");
    a_rx_follows: assert property (wr_b |-> ##[2:3] (rx_active == exp_rx))
        else $error("receive enable does not follow the control write");
    a_soft_clear: assert property ((soft_reset ##1 !pready) |=> (!rx_active && !bit_clock_oe))
        else $error("software reset left control bits set");
    a_load_valid: assert property (tx0_load |-> $past(tx0_data_valid))
        else $error("first transmitter loaded with no data");
    a_load_pulse: assert property (tx0_load |=> !tx0_load)
        else $error("load pulse longer than one cycle");
    a_strobe_pulse: assert property (shift_strobe |=> !shift_strobe)
        else $error("shift strobe longer than one cycle");
    c_soft: cover property (soft_reset ##1 !pready);
    c_load: cover property (tx0_load);
    c_err: cover property (pready && pslverr);
endmodule : serial_port_checker

bind serial_port_clock_frame_control serial_port_checker #(.WORD_BITS(WORD_BITS)) i_checker (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .soft_reset(soft_reset), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .tx0_data_valid(tx0_data_valid), .shift_strobe(shift_strobe), .tx0_load(tx0_load),
    .rx_active(rx_active), .bit_clock_oe(bit_clock_oe));

// File: test/serial_codec_model.sv
/* Far-side model: the first transmit data register and the shift register serial bits.
   Assumes the bench raises auto_fill to keep data ready. */
module serial_codec_model (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       auto_fill,
    input  wire logic       shift_strobe,
    input  wire logic       tx0_load,
    output logic            tx0_data_valid,
    output logic      [2:0] tx_serial
);
    timeunit 1ns;
    timeprecision 1ps;
    // Data is ready whenever auto_fill is high, except in the cycle after each load.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx0_data_valid <= 1'b0;
        end else if (tx0_load) begin
            tx0_data_valid <= 1'b0;
        end else begin
            tx0_data_valid <= auto_fill;
        end
    end
    // The bits change on every strobe so a stale bit cannot pass for a fresh one.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_serial <= 3'h5;
        end else if (shift_strobe) begin
            tx_serial <= ~tx_serial;
        end
    end
endmodule : serial_codec_model

// File: test/serial_port_clock_frame_control_tb_top.sv
/* Self-checking bench for the serial port control block with a far-side model.
   Assumes a four-bit word to keep frames short. */
module serial_port_clock_frame_control_tb_top
    import serial_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WB = 4;
    localparam logic [31:0] ADDR_A = {CTRL_A_INDEX, 2'h0};
    localparam logic [31:0] ADDR_B = {CTRL_B_INDEX, 2'h0};
    logic        sys_clk, sys_rst, soft_reset, psel, penable, pwrite, auto_fill;
    logic [31:0] paddr, pwdata, prdata;
    logic        pready, pslverr, tx0_data_valid, bit_clock_pin, bit_clock_oe;
    logic        sdo_pin, sdo_oe, shift_strobe, frame_sync, tx0_load, rx_active;
    logic [2:0]  tx_serial, tx_active;
    sc_pins_t    mf_pins;
    int          fails, checks_done;

    serial_port_clock_frame_control #(.WORD_BITS(WB)) i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .soft_reset(soft_reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx0_data_valid(tx0_data_valid),
        .tx_serial(tx_serial), .bit_clock_pin(bit_clock_pin), .bit_clock_oe(bit_clock_oe),
        .serial_data_out_pin(sdo_pin), .serial_data_out_oe(sdo_oe), .multifunction_pins(mf_pins),
        .shift_strobe(shift_strobe), .frame_sync(frame_sync), .tx0_load(tx0_load),
        .tx_active(tx_active), .rx_active(rx_active));
    serial_codec_model i_codec (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .auto_fill(auto_fill), .shift_strobe(shift_strobe),
        .tx0_load(tx0_load), .tx0_data_valid(tx0_data_valid), .tx_serial(tx_serial));

    always #5 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [31:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fails++;
            report_and_stop();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task rd(input logic [31:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd

    // Third gap between frame sync rises, or bit clock changes; earlier ones may straddle a write.
    task gap(input logic clk_sel, output int cyc);
        int   n;
        logic prev, cur;
        n = 0;
        for (int k = 0; k < 3; k++) begin
            cyc = 0;
            do begin
                prev = clk_sel ? bit_clock_pin : frame_sync;
                @(posedge sys_clk);
                cur = clk_sel ? bit_clock_pin : frame_sync;
                cyc++;
                n++;
            end while (!(cur === 1'b1 && prev === 1'b0) && !(clk_sel && cur !== prev) && n < 8000);
        end
        if (n >= 8000) begin
            fails++;
            report_and_stop();
        end
    endtask : gap

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task test_regs;
        logic [31:0] r;
        logic        e;
        rd(ADDR_A, r);
        chk(r, 32'h0);
        rd(ADDR_B, r);
        chk(r, 32'h0);
        wr(ADDR_A, 32'h00FFF8FF);
        rd(ADDR_A, r);
        chk(r, 32'h00FFF8FF);
        apb(1'b0, 32'h00000010, 32'h0, r, e);
        chk({r[31:1], e}, 32'h1);
        $display("test_regs done");
    endtask : test_regs

    task test_bit_clock;
        logic [39:0] pms;
        int          c, pm;
        pms = 40'hFF_02_00_03_01;
        for (int i = 0; i < 5; i++) begin
            pm = pms[i*8+:8];
            wr(ADDR_A, 32'(pm) | ((i < 2) ? 32'h800 : 32'h0));
            gap(1'b1, c);
            chk(c, (pm + 1) * ((i < 2) ? 1 : 8));
        end
        $display("test_bit_clock done");
    endtask : test_bit_clock

    task test_frames;
        logic [24:0] ds;
        int          c, d;
        ds = {5'h01, 5'h03, 5'h1F, 5'h05, 5'h00};
        for (int i = 0; i < 5; i++) begin
            d = ds[i*5+:5];
            wr(ADDR_B, (i >= 3) ? 32'h2000 : 32'h0);
            wr(ADDR_A, 32'h801 | 32'(d << 12));
            gap(1'b0, c);
            chk(c, (d + 1) * WB * 4);
        end
        // On-demand: words run only while the first data register holds data.
        wr(ADDR_A, 32'h801);
        for (int k = 0; k < 2; k++) begin
            auto_fill <= (k == 1);
            repeat (40) @(posedge sys_clk);
            d = 0;
            repeat (64) begin
                @(posedge sys_clk);
                d += int'(shift_strobe);
            end
            chk(d, k * 16);
        end
        $display("test_frames done");
    endtask : test_frames

    task test_flags;
        int c, n;
        wr(ADDR_A, 32'h801);
        auto_fill <= 1'b1;
        wr(ADDR_B, 32'h11038);
        auto_fill <= 1'b0;
        gap(1'b0, c);
        wr(ADDR_B, 32'h11039);
        gap(1'b0, c);
        chk(mf_pins.out[1:0], 32'h0);
        auto_fill <= 1'b1;
        n = 0;
        while (tx0_load !== 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 2000) begin
            fails++;
            report_and_stop();
        end
        repeat (3) @(posedge sys_clk);
        chk(mf_pins.out[1:0], 32'h1);
        chk({mf_pins.oe, sdo_oe}, 32'hF);
        c = {frame_sync, tx_serial[0]};
        @(posedge sys_clk);
        chk({mf_pins.out[2], sdo_pin}, c);
        $display("test_flags done");
    endtask : test_flags

    task test_enables;
        logic [31:0] r;
        int          c;
        auto_fill <= 1'b1;
        for (int te = 0; te < 8; te++) begin
            wr(ADDR_B, 32'(te << 14) | 32'(te % 2 << 17));
            gap(1'b0, c);
            chk(tx_active, te);
            chk(rx_active, te % 2);
        end
        @(posedge sys_clk);
        soft_reset <= 1'b1;
        @(posedge sys_clk);
        soft_reset <= 1'b0;
        rd(ADDR_B, r);
        chk(r, 32'h0);
        rd(ADDR_A, r);
        chk(r, 32'h801);
        gap(1'b0, c);
        chk({tx_active, rx_active}, 32'h0);
        $display("test_enables done");
    endtask : test_enables

    initial begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        soft_reset = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        auto_fill = 1'b0;
        fails = 0;
        checks_done = 0;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        test_regs();
        test_bit_clock();
        test_frames();
        test_flags();
        test_enables();
        report_and_stop();
    end
endmodule : serial_port_clock_frame_control_tb_top
